// >>> include/tss_pkg.sv
package tss_pkg;

	localparam int unsigned TSS_AW       = 5;
	localparam int unsigned TSS_DW       = 16;
	localparam int unsigned TSS_QWORDS   = 16;

	typedef logic [TSS_AW-1:0] tss_addr_t;
	typedef logic [TSS_DW-1:0] tss_data_t;

	// Register map, word addresses on the plain port
	localparam tss_addr_t ADDR_QUEUE0    = 5'h00;
	localparam tss_addr_t ADDR_CTRL      = 5'h10;
	localparam tss_addr_t ADDR_STAT      = 5'h11;
	localparam tss_addr_t ADDR_ADJUST    = 5'h12;
	localparam tss_addr_t ADDR_HOLD      = 5'h13;
	localparam tss_addr_t ADDR_LIMIT0    = 5'h14;
	localparam tss_addr_t ADDR_LIMIT1    = 5'h15;
	localparam tss_addr_t ADDR_T0LIM     = 5'h16;
	localparam tss_addr_t ADDR_T1LIM     = 5'h17;
	localparam tss_addr_t ADDR_SDLIM     = 5'h18;
	localparam tss_addr_t ADDR_LITERAL0  = 5'h19;
	localparam tss_addr_t ADDR_QPTR      = 5'h1A;
	localparam tss_addr_t ADDR_COUNT0    = 5'h1B;
	localparam tss_addr_t ADDR_COUNT1    = 5'h1C;
	localparam tss_addr_t ADDR_BTE_LO    = 5'h1D;
	localparam tss_addr_t ADDR_BTE_HI    = 5'h1E;

	// Control and status field positions
	localparam int unsigned CTRL_EN_BIT  = 0;
	localparam int unsigned CTRL_SWT_BIT = 1;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_SDEN_BIT = 1;

	localparam tss_data_t RST_WORD       = 16'h0000;
	localparam logic [4:0] RST_PTR       = 5'h00;
	localparam logic [31:0] RST_BTE      = 32'h0000_0000;

	// Command codes, bits 7-4 of a step byte
	localparam logic [3:0] CMD_CTRL      = 4'h0;
	localparam logic [3:0] CMD_ADD       = 4'h1;
	localparam logic [2:0] CMD_STRB_HI   = 3'h1;
	localparam logic [3:0] CMD_WRISE     = 4'h4;
	localparam logic [3:0] CMD_WFALL     = 4'h5;
	localparam logic [3:0] CMD_IRQ       = 4'h7;
	localparam logic [2:0] CMD_TRIG_HI   = 3'h4;
	localparam logic [2:0] CMD_JMP_HI    = 3'h5;
	localparam logic [2:0] CMD_LOOP0_HI  = 3'h6;
	localparam logic [2:0] CMD_LOOP1_HI  = 3'h7;

	// Control options
	localparam logic [3:0] OPT_SD_OFF    = 4'h2;
	localparam logic [3:0] OPT_SD_ON     = 4'h6;
	localparam logic [3:0] OPT_TMR0      = 4'h8;
	localparam logic [3:0] OPT_TMR1      = 4'h9;
	localparam logic [3:0] OPT_SWT_LVL   = 4'hA;
	localparam logic [3:0] OPT_SWT_EDGE  = 4'hB;
	localparam logic [3:0] OPT_OUT_LIM0  = 4'hC;
	localparam logic [3:0] OPT_OUT_LIM1  = 4'hD;
	localparam logic [3:0] OPT_BCAST     = 4'hF;

	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] opt;
	} tss_step_t;

	typedef enum {
		ST_IDLE,
		ST_EXEC,
		ST_WAIT_IN,
		ST_WAIT_TMR,
		ST_WAIT_SWL,
		ST_WAIT_SWE,
		ST_DELAY
	} tss_state_t;

endpackage : tss_pkg

// >>> src/tss_sequencer.sv
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - Queue word holds two step bytes; upper byte odd step, lower even step.
// - Queue words ignore writes while steps are executing.
// - Byte is code bits 7-4, option bits 3-0; control option zero is nop.
// - Add code with option bit 3 clear adds adjust value to chosen target.
// - Copy options 1000-1101 load hold value into the chosen target.
// - Codes 001x strobe ADC conversion, channel is code bit 0 with option.
// - Code 0100 waits for rising edge on selected trigger input.
// - Code 0101 waits for falling edge on selected trigger input.
// - Reserved codes and options execute as no-operation.
// - Code 0111 pulses interrupt 0-7; options 1000 and up are no-ops.
// - Codes 100x pulse one of 32 trigger outputs.
// - Codes 101x load the 5-bit target into queue pointer and continue.
// - Codes 110x advance on counter0 match, else increment counter0 and jump.
// - Codes 111x do the same with counter1 and its limit.
// - Control options 0010 and 0110 disable and enable the step delay.
// - Options 1000 and 1001 run timer0 or timer1 until limit match.
// - Option 1010 waits for software trigger level, 1011 for its rising edge.
// - Options 1100 and 1101 put loop limit 0 or 1 on strobe bus.
// - Option 1111 pulses every trigger output enabled in broadcast register.
// - Five-bit queue pointer names current step, read-only while running.
module tss_sequencer (
	input  wire logic               CLK_I,
	input  wire logic               RST_N_I,
	input  wire tss_pkg::tss_addr_t ADDR_I,
	input  wire tss_pkg::tss_data_t WDATA_I,
	input  wire logic               WR_I,
	input  wire logic               RD_I,
	output tss_pkg::tss_data_t      RDATA_O,
	input  wire logic [15:0]        TRIG_IN_I,
	output logic [31:0]             TRIG_O,
	output logic [7:0]              IRQ_O,
	output logic                    ADC_STRB_O,
	output logic [4:0]              ADC_CHAN_O,
	output tss_pkg::tss_data_t      STRB_BUS_O,
	output logic                    STRB_VALID_O,
	output logic                    BUSY_O
);
	import tss_pkg::*;

	tss_data_t  queue_r [TSS_QWORDS];
	tss_data_t  adj_r;
	tss_data_t  hold_r;
	tss_data_t  lim0_r;
	tss_data_t  lim1_r;
	tss_data_t  t0lim_r;
	tss_data_t  t1lim_r;
	tss_data_t  sdlim_r;
	tss_data_t  lit0_r;
	tss_data_t  cnt0_r;
	tss_data_t  cnt1_r;
	tss_data_t  tmr_r;
	logic [31:0] bte_r;
	logic [4:0] ptr_r;
	logic       en_r;
	logic       swt_r;
	logic       swt_prev_r;
	logic       sd_en_r;
	tss_state_t state_r;
	logic [15:0] in_s1_r;
	logic [15:0] in_s2_r;
	logic [15:0] in_s3_r;
	logic [15:0] in_filt_r;
	logic [15:0] in_filt_nxt;
	logic [15:0] rise_r;
	logic [15:0] fall_r;
	tss_step_t  step;
	tss_data_t  word;
	logic [4:0] sel5;
	logic       exec_v;
	logic       busy;
	logic       wait_ok;
	logic       q_wr;

	assign busy   = (state_r != ST_IDLE);
	// Gated by enable so a step cut short by a stop is not applied twice on resume
	assign exec_v = (state_r == ST_EXEC) && en_r;
	assign word   = queue_r[ptr_r[4:1]];
	assign step   = ptr_r[0] ? word[15:8] : word[7:0];
	assign sel5   = {step.cmd[0], step.opt};
	assign q_wr   = WR_I && !ADDR_I[4];

	// Trigger inputs: only the second and third stages feed the filter
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			in_s1_r <= 16'h0000;
			in_s2_r <= 16'h0000;
			in_s3_r <= 16'h0000;
		end
		else
		begin
			in_s1_r <= TRIG_IN_I;
			in_s2_r <= in_s1_r;
			in_s3_r <= in_s2_r;
		end
	end

	assign in_filt_nxt = (in_s2_r & in_s3_r) | (in_filt_r & (in_s2_r | in_s3_r));

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			in_filt_r <= 16'h0000;
			rise_r    <= 16'h0000;
			fall_r    <= 16'h0000;
		end
		else
		begin
			in_filt_r <= in_filt_nxt;
			rise_r    <= in_filt_nxt & ~in_filt_r;
			fall_r    <= ~in_filt_nxt & in_filt_r;
		end
	end

	// Queue storage, frozen while running
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			for (int i = 0; i < TSS_QWORDS; i++)
				queue_r[i] <= RST_WORD;
		end
		else if (q_wr && !busy)
		begin
			queue_r[ADDR_I[3:0]] <= WDATA_I;
		end
	end

	// Control word and broadcast enables stay writable while running
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			en_r       <= 1'b0;
			swt_r      <= 1'b0;
			swt_prev_r <= 1'b0;
			bte_r      <= RST_BTE;
		end
		else
		begin
			swt_prev_r <= swt_r;
			if (WR_I && ADDR_I == ADDR_CTRL)
			begin
				en_r  <= WDATA_I[CTRL_EN_BIT];
				swt_r <= WDATA_I[CTRL_SWT_BIT];
			end
			if (WR_I && ADDR_I == ADDR_BTE_LO)
				bte_r[15:0] <= WDATA_I;
			if (WR_I && ADDR_I == ADDR_BTE_HI)
				bte_r[31:16] <= WDATA_I;
		end
	end

	// Limit set: software while idle, add and copy steps while running
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			adj_r   <= RST_WORD;
			hold_r  <= RST_WORD;
			lim0_r  <= RST_WORD;
			lim1_r  <= RST_WORD;
			t0lim_r <= RST_WORD;
			t1lim_r <= RST_WORD;
			sdlim_r <= RST_WORD;
			lit0_r  <= RST_WORD;
		end
		else if (!busy)
		begin
			if (WR_I)
			begin
				case (ADDR_I)
					ADDR_ADJUST:   adj_r   <= WDATA_I;
					ADDR_HOLD:     hold_r  <= WDATA_I;
					ADDR_LIMIT0:   lim0_r  <= WDATA_I;
					ADDR_LIMIT1:   lim1_r  <= WDATA_I;
					ADDR_T0LIM:    t0lim_r <= WDATA_I;
					ADDR_T1LIM:    t1lim_r <= WDATA_I;
					ADDR_SDLIM:    sdlim_r <= WDATA_I;
					ADDR_LITERAL0: lit0_r  <= WDATA_I;
					default:       ;
				endcase
			end
		end
		else if (exec_v && step.cmd == CMD_ADD)
		begin
			// Bit 3 picks copy over add; options x110 and x111 fall through
			case (step.opt[2:0])
				3'h0: lim0_r  <= step.opt[3] ? hold_r : lim0_r + adj_r;
				3'h1: lim1_r  <= step.opt[3] ? hold_r : lim1_r + adj_r;
				3'h2: t0lim_r <= step.opt[3] ? hold_r : t0lim_r + adj_r;
				3'h3: t1lim_r <= step.opt[3] ? hold_r : t1lim_r + adj_r;
				3'h4: sdlim_r <= step.opt[3] ? hold_r : sdlim_r + adj_r;
				3'h5: lit0_r  <= step.opt[3] ? hold_r : lit0_r + adj_r;
				default: ;
			endcase
		end
	end

	// Wait conditions
	always_comb
	begin
		wait_ok = 1'b0;
		case (state_r)
			ST_WAIT_IN:  wait_ok = step.cmd[0] ? fall_r[step.opt] : rise_r[step.opt];
			ST_WAIT_TMR: wait_ok = (tmr_r == (step.opt[0] ? t1lim_r : t0lim_r));
			ST_WAIT_SWL: wait_ok = swt_r;
			ST_WAIT_SWE: wait_ok = swt_r && !swt_prev_r;
			default:     wait_ok = 1'b0;
		endcase
	end

	// Step engine: pointer, loop counters, timer, delay enable
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			state_r <= ST_IDLE;
			ptr_r   <= RST_PTR;
			cnt0_r  <= RST_WORD;
			cnt1_r  <= RST_WORD;
			tmr_r   <= RST_WORD;
			sd_en_r <= 1'b0;
		end
		else if (!en_r)
		begin
			state_r <= ST_IDLE;
			if (WR_I && ADDR_I == ADDR_QPTR)
				ptr_r <= WDATA_I[4:0];
			if (WR_I && ADDR_I == ADDR_COUNT0)
				cnt0_r <= WDATA_I;
			if (WR_I && ADDR_I == ADDR_COUNT1)
				cnt1_r <= WDATA_I;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					state_r <= ST_EXEC;
				end
				ST_EXEC:
				begin
					tmr_r   <= RST_WORD;
					ptr_r   <= ptr_r + 5'h01;
					state_r <= sd_en_r ? ST_DELAY : ST_EXEC;
					if (step.cmd == CMD_CTRL)
					begin
						case (step.opt)
							OPT_SD_OFF:   sd_en_r <= 1'b0;
							OPT_SD_ON:    sd_en_r <= 1'b1;
							OPT_TMR0,
							OPT_TMR1:
							begin
								ptr_r   <= ptr_r;
								state_r <= ST_WAIT_TMR;
							end
							OPT_SWT_LVL:
							begin
								ptr_r   <= ptr_r;
								state_r <= ST_WAIT_SWL;
							end
							OPT_SWT_EDGE:
							begin
								ptr_r   <= ptr_r;
								state_r <= ST_WAIT_SWE;
							end
							default:      ;
						endcase
					end
					else if (step.cmd == CMD_WRISE || step.cmd == CMD_WFALL)
					begin
						ptr_r   <= ptr_r;
						state_r <= ST_WAIT_IN;
					end
					else if (step.cmd[3:1] == CMD_JMP_HI)
					begin
						ptr_r <= sel5;
					end
					else if (step.cmd[3:1] == CMD_LOOP0_HI && cnt0_r != lim0_r)
					begin
						cnt0_r <= cnt0_r + 16'h0001;
						ptr_r  <= sel5;
					end
					else if (step.cmd[3:1] == CMD_LOOP1_HI && cnt1_r != lim1_r)
					begin
						cnt1_r <= cnt1_r + 16'h0001;
						ptr_r  <= sel5;
					end
				end
				ST_WAIT_IN,
				ST_WAIT_TMR,
				ST_WAIT_SWL,
				ST_WAIT_SWE:
				begin
					if (wait_ok)
					begin
						tmr_r   <= RST_WORD;
						ptr_r   <= ptr_r + 5'h01;
						state_r <= sd_en_r ? ST_DELAY : ST_EXEC;
					end
					else if (state_r == ST_WAIT_TMR)
					begin
						tmr_r <= tmr_r + 16'h0001;
					end
				end
				ST_DELAY:
				begin
					// Delay of limit+1 cycles keeps a zero limit from racing
					if (tmr_r == sdlim_r)
						state_r <= ST_EXEC;
					else
						tmr_r <= tmr_r + 16'h0001;
				end
				default:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Step outputs, single-cycle pulses except the ADC channel and strobe bus values
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			TRIG_O       <= 32'h0000_0000;
			IRQ_O        <= 8'h00;
			ADC_STRB_O   <= 1'b0;
			ADC_CHAN_O   <= 5'h00;
			STRB_BUS_O   <= RST_WORD;
			STRB_VALID_O <= 1'b0;
		end
		else
		begin
			TRIG_O       <= 32'h0000_0000;
			IRQ_O        <= 8'h00;
			ADC_STRB_O   <= 1'b0;
			STRB_VALID_O <= 1'b0;
			if (exec_v)
			begin
				if (step.cmd[3:1] == CMD_STRB_HI)
				begin
					ADC_STRB_O <= 1'b1;
					ADC_CHAN_O <= sel5;
				end
				if (step.cmd[3:1] == CMD_TRIG_HI)
					TRIG_O <= 32'h0000_0001 << sel5;
				if (step.cmd == CMD_IRQ && !step.opt[3])
					IRQ_O <= 8'h01 << step.opt[2:0];
				if (step.cmd == CMD_CTRL && step.opt == OPT_BCAST)
					TRIG_O <= bte_r;
				if (step.cmd == CMD_CTRL && (step.opt == OPT_OUT_LIM0 || step.opt == OPT_OUT_LIM1))
				begin
					STRB_BUS_O   <= step.opt[0] ? lim1_r : lim0_r;
					STRB_VALID_O <= 1'b1;
				end
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			RDATA_O <= RST_WORD;
			BUSY_O  <= 1'b0;
		end
		else
		begin
			BUSY_O  <= busy;
			RDATA_O <= RST_WORD;
			if (RD_I)
			begin
				if (!ADDR_I[4])
					RDATA_O <= queue_r[ADDR_I[3:0]];
				else
				begin
					case (ADDR_I)
						ADDR_CTRL:     RDATA_O <= {14'h0000, swt_r, en_r};
						ADDR_STAT:     RDATA_O <= {14'h0000, sd_en_r, busy};
						ADDR_ADJUST:   RDATA_O <= adj_r;
						ADDR_HOLD:     RDATA_O <= hold_r;
						ADDR_LIMIT0:   RDATA_O <= lim0_r;
						ADDR_LIMIT1:   RDATA_O <= lim1_r;
						ADDR_T0LIM:    RDATA_O <= t0lim_r;
						ADDR_T1LIM:    RDATA_O <= t1lim_r;
						ADDR_SDLIM:    RDATA_O <= sdlim_r;
						ADDR_LITERAL0: RDATA_O <= lit0_r;
						ADDR_QPTR:     RDATA_O <= {11'h000, ptr_r};
						ADDR_COUNT0:   RDATA_O <= cnt0_r;
						ADDR_COUNT1:   RDATA_O <= cnt1_r;
						ADDR_BTE_LO:   RDATA_O <= bte_r[15:0];
						ADDR_BTE_HI:   RDATA_O <= bte_r[31:16];
						default:       RDATA_O <= RST_WORD;
					endcase
				end
			end
		end
	end

	// Checks
	sequence s_exec(logic [3:0] c);
		exec_v && en_r && step.cmd == c;
	endsequence

	property p_queue_ro;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(busy && q_wr) |=> queue_r[$past(ADDR_I[3:0])] == $past(queue_r[ADDR_I[3:0]]);
	endproperty
	a_queue_ro: assert property (p_queue_ro) else $error("queue word changed while running");

	property p_adc;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && step.cmd[3:1] == CMD_STRB_HI) |=> ADC_STRB_O && ADC_CHAN_O == $past(sel5);
	endproperty
	a_adc: assert property (p_adc) else $error("ADC strobe or channel wrong");

	property p_trig;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && step.cmd[3:1] == CMD_TRIG_HI) |=> TRIG_O == (32'h0000_0001 << $past(sel5));
	endproperty
	a_trig: assert property (p_trig) else $error("trigger output wrong");

	property p_irq_rsvd;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(s_exec(CMD_IRQ) and (step.opt[3] == 1'b1)) |=> IRQ_O == 8'h00 && ptr_r == $past(ptr_r) + 5'h01;
	endproperty
	a_irq_rsvd: assert property (p_irq_rsvd) else $error("reserved interrupt option fired");

	property p_jump;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && en_r && step.cmd[3:1] == CMD_JMP_HI) |=> ptr_r == $past(sel5);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded");

	property p_loop0;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && en_r && step.cmd[3:1] == CMD_LOOP0_HI && cnt0_r == lim0_r)
			|=> ptr_r == $past(ptr_r) + 5'h01 && $stable(cnt0_r);
	endproperty
	a_loop0: assert property (p_loop0) else $error("loop 0 match did not advance");

	property p_wait_hold;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_r == ST_WAIT_IN && !wait_ok && en_r) |=> $stable(ptr_r) && !exec_v;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("edge wait left early");

	property p_bcast;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(s_exec(CMD_CTRL) and (step.opt == OPT_BCAST)) |=> TRIG_O == $past(bte_r);
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast triggers wrong");

	property p_nop;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(s_exec(4'h6) and !sd_en_r) |=> TRIG_O == 32'h0000_0000 && ptr_r == $past(ptr_r) + 5'h01 && exec_v;
	endproperty
	a_nop: assert property (p_nop) else $error("reserved code had an effect");

	property p_loop1;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && step.cmd[3:1] == CMD_LOOP1_HI && cnt1_r != lim1_r)
			|=> ptr_r == $past(sel5) && cnt1_r == $past(cnt1_r) + 16'h0001;
	endproperty
	a_loop1: assert property (p_loop1) else $error("loop 1 jump wrong");

	property p_delay_start;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(exec_v && sd_en_r && step.cmd[3:1] == CMD_TRIG_HI) |=> state_r == ST_DELAY && tmr_r == RST_WORD;
	endproperty
	a_delay_start: assert property (p_delay_start) else $error("step delay not entered");

	property p_delay;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_r == ST_DELAY && en_r && tmr_r != sdlim_r)
			|=> state_r == ST_DELAY && tmr_r == $past(tmr_r) + 16'h0001;
	endproperty
	a_delay: assert property (p_delay) else $error("step delay ended early");

	property p_tmr_run;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_r == ST_WAIT_TMR && en_r && !wait_ok) |=> $stable(ptr_r) && tmr_r == $past(tmr_r) + 16'h0001;
	endproperty
	a_tmr_run: assert property (p_tmr_run) else $error("timer wait did not count");

endmodule : tss_sequencer

// >>> tb/tss_far_model.sv
`timescale 1ns/100ps
module tss_far_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        pin4_lvl_i,
	output logic [15:0]      trig_in_o
);
	logic [3:0] cnt_r;

	// Other inputs keep toggling so a wait must pick only its own input
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_r + 4'h1;
	end

	always_ff @(posedge clk_i)
	begin
		trig_in_o <= {{11{cnt_r[3]}}, pin4_lvl_i, {4{~cnt_r[3]}}};
	end
endmodule : tss_far_model

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
	import tss_pkg::*;
	logic               CLK_I;
	logic               RST_N_I;
	tss_addr_t          ADDR_I;
	tss_data_t          WDATA_I;
	logic               WR_I;
	logic               RD_I;
	tss_data_t          RDATA_O;
	logic [15:0]        TRIG_IN_I;
	logic [31:0]        TRIG_O;
	logic [7:0]         IRQ_O;
	logic               ADC_STRB_O;
	logic [4:0]         ADC_CHAN_O;
	tss_data_t          STRB_BUS_O;
	logic               STRB_VALID_O;
	logic               BUSY_O;
	logic               pin4;
	logic               rd_pend;
	logic [62:0]        eq[$];
	tss_data_t          rq[$];
	logic [7:0]         prog[32];
	tss_data_t          adj, hold, lim1;
	logic [31:0]        bte;
	logic [62:0]        ev;
	int                 bad_count;
	int                 checks_done;

	tss_sequencer i_dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
		.RD_I(RD_I), .RDATA_O(RDATA_O), .TRIG_IN_I(TRIG_IN_I), .TRIG_O(TRIG_O), .IRQ_O(IRQ_O),
		.ADC_STRB_O(ADC_STRB_O), .ADC_CHAN_O(ADC_CHAN_O), .STRB_BUS_O(STRB_BUS_O),
		.STRB_VALID_O(STRB_VALID_O), .BUSY_O(BUSY_O));

	tss_far_model i_far (.clk_i(CLK_I), .rst_n_i(RST_N_I), .pin4_lvl_i(pin4), .trig_in_o(TRIG_IN_I));

	initial
	begin
		CLK_I = 1'b0;
		forever #2.5 CLK_I = ~CLK_I;
	end

	task automatic chk(input string name, input logic [62:0] seen, input logic [62:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	// Event layout: trig, irq, adc strobe, channel, strobe valid, bus
	function automatic logic [62:0] tr(input int n);
		return {32'h0000_0001 << n, 31'h0};
	endfunction : tr

	// Outputs are registered, so sampling at the edge sees each pulse once
	always @(posedge CLK_I)
	begin
		if (rd_pend)
			chk("rdata", {47'h0, RDATA_O}, {47'h0, rq.pop_front()});
		rd_pend <= RD_I;
		// Outputs are unknown until the first reset edge has landed
		if (RST_N_I && {TRIG_O, IRQ_O, ADC_STRB_O, STRB_VALID_O} !== 42'h0)
		begin
			ev = {TRIG_O, IRQ_O, ADC_STRB_O, ADC_STRB_O ? ADC_CHAN_O : 5'h00, STRB_VALID_O,
				STRB_VALID_O ? STRB_BUS_O : 16'h0000};
			if (eq.size() == 0)
				chk("unexpected event", ev, 63'h0);
			else
				chk("event", ev, eq.pop_front());
		end
	end

	task automatic wr(input tss_addr_t a, input tss_data_t d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask : wr

	task automatic rd(input tss_addr_t a, input tss_data_t exp);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		rq.push_back(exp);
		@(posedge CLK_I);
		RD_I <= 1'b0;
	endtask : rd

	task automatic drain;
		int n;
		n = 0;
		while ((eq.size() != 0 || rq.size() != 0) && n < 2000)
		begin
			@(posedge CLK_I);
			n++;
		end
		if (n >= 2000)
		begin
			bad_count++;
			$display("MISMATCH drain expected empty seen %0d", eq.size());
			tally_and_finish();
		end
		repeat (20) @(posedge CLK_I);
	endtask : drain

	initial
	begin
		bad_count = 0;
		checks_done = 0;
		RST_N_I = 1'b0;
		ADDR_I = '0;
		WDATA_I = '0;
		WR_I = 1'b0;
		RD_I = 1'b0;
		pin4 = 1'b0;
		rd_pend = 1'b0;
		void'($urandom(14664));
		adj = tss_data_t'($urandom);
		hold = tss_data_t'($urandom);
		lim1 = tss_data_t'($urandom);
		bte = $urandom | 32'h0000_0001;
		prog = '{8'h8C, 8'h9F, 8'h75, 8'h78, 8'h60, 8'h2A, 8'h3F, 8'h11, 8'h0D, 8'h19, 8'h0D, 8'h0F, 8'h44,
			8'h80, 8'h54, 8'h81, 8'h0A, 8'h82, 8'hD1, 8'hB7, 8'h83, 8'h83, 8'h83, 8'h0C, 8'h00, 8'h08,
			8'h84, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (8) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		rd(ADDR_LIMIT0, 16'h0000);
		rd(ADDR_QPTR, 16'h0000);
		rd(5'h03, RST_WORD);
		rd(5'h1F, 16'h0000);
		// Everything is loaded before the engine starts
		for (int n = 0; n < 16; n++)
			wr(tss_addr_t'(n), {prog[2*n+1], prog[2*n]});
		rd(5'h00, 16'h9F8C);
		wr(ADDR_ADJUST, adj);
		wr(ADDR_HOLD, hold);
		wr(ADDR_LIMIT0, 16'h0001);
		wr(ADDR_LIMIT1, lim1);
		wr(ADDR_T0LIM, 16'h0005);
		wr(ADDR_BTE_LO, bte[15:0]);
		wr(ADDR_BTE_HI, bte[31:16]);
		eq.push_back(tr(12));
		eq.push_back(tr(31));
		eq.push_back({32'h0, 8'h20, 23'h0});
		eq.push_back({40'h0, 1'b1, 5'h0A, 17'h0});
		eq.push_back({40'h0, 1'b1, 5'h1F, 17'h0});
		eq.push_back({46'h0, 1'b1, tss_data_t'(lim1 + adj)});
		eq.push_back({46'h0, 1'b1, hold});
		eq.push_back({bte, 31'h0});
		wr(ADDR_CTRL, 16'h0001);
		drain();
		rd(ADDR_QPTR, 16'h000C);
		rd(ADDR_STAT, 16'h0001);
		pin4 <= 1'b1;
		eq.push_back(tr(0));
		drain();
		rd(ADDR_QPTR, 16'h000E);
		pin4 <= 1'b0;
		eq.push_back(tr(1));
		drain();
		rd(ADDR_QPTR, 16'h0010);
		eq.push_back(tr(2));
		eq.push_back(tr(2));
		eq.push_back({46'h0, 1'b1, 16'h0001});
		eq.push_back(tr(4));
		wr(ADDR_CTRL, 16'h0003);
		drain();
		rd(ADDR_QPTR, 16'h001B);
		rd(ADDR_COUNT0, 16'h0001);
		wr(5'h00, 16'hFFFF);
		rd(5'h00, 16'h9F8C);
		wr(ADDR_CTRL, 16'h0000);
		repeat (4) @(posedge CLK_I);
		chk("busy idle", {62'h0, BUSY_O}, 63'h0);
		wr(5'h00, 16'h1234);
		rd(5'h00, 16'h1234);
		// Second program: step delay, loop 1, timer 1, add and copy targets
		wr(ADDR_QPTR, 16'h0000);
		wr(ADDR_SDLIM, 16'h0003);
		wr(ADDR_LIMIT1, 16'h0002);
		wr(ADDR_T1LIM, 16'h0004);
		wr(5'h00, 16'h8A06);
		wr(5'h01, 16'h02E1);
		wr(5'h02, 16'h1209);
		wr(5'h03, 16'h701C);
		wr(5'h04, 16'h000A);
		for (int n = 0; n < 3; n++)
			eq.push_back(tr(10));
		eq.push_back({32'h0, 8'h01, 23'h0});
		wr(ADDR_CTRL, 16'h0001);
		drain();
		wr(ADDR_QPTR, 16'h0003);
		rd(ADDR_QPTR, 16'h0008);
		rd(ADDR_COUNT1, 16'h0002);
		rd(ADDR_T0LIM, tss_data_t'(16'h0005 + adj));
		rd(ADDR_SDLIM, hold);
		chk("busy running", {62'h0, BUSY_O}, 63'h1);
		drain();
		tally_and_finish();
	end
endmodule : tb
